// ===== rtl/trig_dio_consts.svh
// Constants for the trigger and general-purpose line port.
`ifndef TRIG_DIO_CONSTS_SVH
`define TRIG_DIO_CONSTS_SVH
`define LINE_COUNT 16
`define PORT_SEL_W 5
`define PORT_SEL_DEDICATED 5'h00
`define LINE_HIGH_INIT 16'hffff
`define LINE_ZERO 16'h0000
`define CLK_PERIOD_NS 25
`define PULSE_LAG_US 110
`define PULSE_LAG_CYC ((`PULSE_LAG_US * 1000) / `CLK_PERIOD_NS)
`define LAG_CNT_W 16
`define DELAY_W 24
`define DELAY_ZERO 24'h000000
`define TYPE_START_MEAS 2'h1
`define TYPE_SWEEP_STEP 2'h2
`define TYPE_STEP_MEAS 2'h3
`endif

// ===== rtl/trig_dio_pkg.sv
// Types shared by the trigger and general-purpose line port.
package trig_dio_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY
  } delay_state_t;

  typedef struct packed {
    logic [4:0] in_port;
    logic [1:0] in_type;
    logic rising;
    logic [4:0] out_port;
    logic out_rising;
  } trig_cfg_t;

  typedef struct packed {
    logic start_meas;
    logic sweep_step;
    logic pulse_start;
    logic step_meas;
    logic wait_release;
  } trig_evt_t;
endpackage

// ===== rtl/edge_sync.sv
// Two-stage synchroniser with a polarity-selected edge detector.
`timescale 1ns/100ps
module edge_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Line and polarity
  input wire logic line_i,
  input wire logic rising_i,
  // Result
  output logic level_o,
  output logic edge_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic edge_p;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = line_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // Polarity is applied after synchronising, so only settled samples are compared.
    st_nxt.edge_p = rising_i ? (st_r.s2 & ~st_r.s3) : (~st_r.s2 & st_r.s3); // RL14 RL5
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= 4'hf;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.s2;
  assign edge_o = st_r.edge_p;
endmodule

// ===== rtl/trig_dio_port.sv
// Trigger input routing and general-purpose line control.
`timescale 1ns/100ps
`include "trig_dio_consts.svh"
// How it works
// (RL1) After reset every general line drives high until a set command changes it.
// (RL2) Sixteen lines; port setup may claim one line as trigger input or output.
// (RL3) Assign, status and set commands only touch lines not claimed as trigger ports.
// (RL4) Dedicated trigger input only receives, dedicated output only sends.
// (RL5) Falling edge triggers by default; polarity setting selects rising edge.
// (RL6) Far side holds each trigger pulse at least 10 us.
// (RL7) Reset selects dedicated input terminal and trigger type 1.
// (RL8) Type 1 trigger starts the selected measurement when external event mode is on.
// (RL9) Type 2 starts sweep step output; pulse output follows 110 us later.
// (RL10) Type 3 waits the measurement trigger delay, then starts the step measurement.
// (RL11) A programmable delay is loaded by the delay commands.
// (RL12) A wait state is released by a trigger on the selected port, any type.
// (RL13) Controller selects external event mode before timed pause commands.
// (RL14) Trigger inputs are synchronised and yield one pulse per accepted edge; edge_sync also resets with its pulse set, so one pulse follows reset.
module trig_dio_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Port setup command
  input wire logic setup_cmd_i,
  input wire logic setup_input_i,
  input wire logic [4:0] setup_port_i,
  input wire logic [1:0] setup_type_i,
  input wire logic setup_rising_i,
  // Line commands
  input wire logic assign_cmd_i,
  input wire logic [15:0] assign_out_i,
  input wire logic set_cmd_i,
  input wire logic [15:0] set_value_i,
  input wire logic [15:0] set_mask_i,
  input wire logic status_query_i,
  // Delay and modes
  input wire logic delay_cmd_i,
  input wire logic [23:0] delay_cycles_i,
  input wire logic external_event_mode_i,
  input wire logic trigger_wait_cmd_i,
  input wire logic timed_pause_cmd_i,
  input wire logic send_trig_i,
  // Pins
  input wire logic ext_trig_in_i,
  output logic ext_trig_out_o,
  input wire logic [15:0] line_i,
  output logic [15:0] line_o,
  output logic [15:0] line_oe_o,
  // Status and events
  output logic [15:0] status_o,
  output logic status_valid_o,
  output logic waiting_o,
  output trig_dio_pkg::trig_evt_t evt_o
);
  // --------------------------------------------------------------------
  // State and local signals.
  // --------------------------------------------------------------------
  typedef struct packed {
    trig_dio_pkg::trig_cfg_t cfg;
    logic [15:0] out_val;
    logic [15:0] dir_out;
    logic [15:0] status;
    logic status_valid;
    logic [23:0] delay;
    logic [23:0] delay_cnt;
    trig_dio_pkg::delay_state_t dstate;
    logic lag_busy;
    logic [15:0] lag_cnt;
    logic waiting;
    logic trig_out;
    logic [15:0] line_q;
    logic [15:0] oe_q;
    trig_dio_pkg::trig_evt_t evt;
  } port_state_t;

  port_state_t st_r;
  port_state_t st_nxt;
  logic [16:0] raw_in;
  logic [16:0] lvl;
  logic [16:0] edg;
  logic [15:0] trig_mask;
  logic trig_evt;

  // --------------------------------------------------------------------
  // Port code decoding.
  // --------------------------------------------------------------------
  // Codes 1 to 16 name lines 1 to 16; code 16 wraps its low nibble round to index 15.
  function automatic logic [3:0] line_index(input logic [4:0] sel);
    return sel[3:0] - 4'h1;
  endfunction

  function automatic logic [15:0] port_mask(input logic [4:0] sel);
    logic [15:0] m;
    m = `LINE_ZERO;
    if (sel != `PORT_SEL_DEDICATED) begin
      m[line_index(sel)] = 1'b1;
    end
    return m;
  endfunction

  // --------------------------------------------------------------------
  // Input synchronisers.
  // --------------------------------------------------------------------
  assign raw_in = {line_i, ext_trig_in_i};

  for (genvar g = 0; g <= `LINE_COUNT; g++) begin : g_sync
    edge_sync u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .line_i(raw_in[g]),
      .rising_i(st_r.cfg.rising),
      .level_o(lvl[g]),
      .edge_o(edg[g])
    );
  end

  // Lines claimed by either trigger port.
  assign trig_mask = port_mask(st_r.cfg.in_port) | port_mask(st_r.cfg.out_port); // RL2
  assign trig_evt = edg[st_r.cfg.in_port]; // RL14

  // --------------------------------------------------------------------
  // Command and event logic.
  // --------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.evt = '0;
    st_nxt.status_valid = 1'b0;
    if (setup_cmd_i) begin
      if (setup_input_i) begin
        st_nxt.cfg.in_port = setup_port_i;
        st_nxt.cfg.in_type = setup_type_i;
        st_nxt.cfg.rising = setup_rising_i; // RL5
      end else begin
        st_nxt.cfg.out_port = setup_port_i;
        st_nxt.cfg.out_rising = setup_rising_i;
      end
    end
    if (assign_cmd_i) begin
      st_nxt.dir_out = (st_r.dir_out & trig_mask) | (assign_out_i & ~trig_mask); // RL3
    end
    if (set_cmd_i) begin
      st_nxt.out_val = (st_r.out_val & ~(set_mask_i & ~trig_mask))
                     | (set_value_i & set_mask_i & ~trig_mask); // RL3 RL1
    end
    if (status_query_i) begin
      st_nxt.status = lvl[16:1] & ~trig_mask; // RL3
      st_nxt.status_valid = 1'b1;
    end
    if (delay_cmd_i) begin
      st_nxt.delay = delay_cycles_i; // RL11
    end
    // The dedicated output never turns round; only lines switch direction.
    st_nxt.trig_out = send_trig_i ? st_r.cfg.out_rising : ~st_r.cfg.out_rising; // RL4
    st_nxt.line_q = st_r.out_val;
    st_nxt.oe_q = st_r.dir_out & ~port_mask(st_r.cfg.in_port);
    if (st_r.cfg.out_port != `PORT_SEL_DEDICATED) begin
      st_nxt.line_q[line_index(st_r.cfg.out_port)] = st_nxt.trig_out;
      st_nxt.oe_q[line_index(st_r.cfg.out_port)] = 1'b1; // RL2
    end
    if (trigger_wait_cmd_i || (timed_pause_cmd_i && external_event_mode_i)) begin
      st_nxt.waiting = 1'b1; // RL13
    end
    if (st_r.waiting && trig_evt) begin
      st_nxt.waiting = 1'b0; // RL12
      st_nxt.evt.wait_release = 1'b1;
    end
    if (trig_evt && !st_r.waiting) begin
      case (st_r.cfg.in_type)
        `TYPE_START_MEAS: st_nxt.evt.start_meas = external_event_mode_i; // RL8
        `TYPE_SWEEP_STEP: begin
          st_nxt.evt.sweep_step = 1'b1; // RL9
          st_nxt.lag_busy = 1'b1;
          st_nxt.lag_cnt = `LAG_CNT_W'(`PULSE_LAG_CYC - 1);
        end
        `TYPE_STEP_MEAS: begin
          st_nxt.dstate = trig_dio_pkg::ST_DELAY; // RL10
          st_nxt.delay_cnt = st_r.delay;
        end
        default: ;
      endcase
    end
    if (st_r.lag_busy) begin
      if (st_r.lag_cnt == `LAG_CNT_W'(0)) begin
        st_nxt.lag_busy = 1'b0;
        st_nxt.evt.pulse_start = 1'b1; // RL9
      end else begin
        st_nxt.lag_cnt = st_r.lag_cnt - `LAG_CNT_W'(1);
      end
    end
    case (st_r.dstate)
      trig_dio_pkg::ST_IDLE: ;
      trig_dio_pkg::ST_DELAY: begin
        if (st_r.delay_cnt == `DELAY_ZERO) begin
          st_nxt.dstate = trig_dio_pkg::ST_IDLE;
          st_nxt.evt.step_meas = 1'b1; // RL10
        end else begin
          st_nxt.delay_cnt = st_r.delay_cnt - `DELAY_W'(1);
        end
      end
      default: st_nxt.dstate = trig_dio_pkg::ST_IDLE;
    endcase
  end

  // --------------------------------------------------------------------
  // State register.
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.cfg.in_port <= `PORT_SEL_DEDICATED; // RL7
      st_r.cfg.in_type <= `TYPE_START_MEAS; // RL7
      st_r.cfg.out_port <= `PORT_SEL_DEDICATED;
      st_r.out_val <= `LINE_HIGH_INIT; // RL1
      st_r.dir_out <= `LINE_HIGH_INIT; // RL1
      st_r.line_q <= `LINE_HIGH_INIT;
      st_r.oe_q <= `LINE_HIGH_INIT;
      st_r.trig_out <= 1'b1;
      st_r.dstate <= trig_dio_pkg::ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Outputs.
  // --------------------------------------------------------------------
  assign ext_trig_out_o = st_r.trig_out;
  assign line_o = st_r.line_q;
  assign line_oe_o = st_r.oe_q;
  assign status_o = st_r.status;
  assign status_valid_o = st_r.status_valid;
  assign waiting_o = st_r.waiting;
  assign evt_o = st_r.evt;
endmodule

// ===== verif/trig_dio_port_props.sv
// Checker for the trigger and general line port.
`timescale 1ns/100ps
module trig_dio_port_props (
  // Clock, reset and commands
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic status_query_i,
  input wire logic trigger_wait_cmd_i,
  input wire logic timed_pause_cmd_i,
  input wire logic external_event_mode_i,
  // Outputs watched
  input wire logic [15:0] line_o,
  input wire logic [15:0] line_oe_o,
  input wire logic status_valid_o,
  input wire logic waiting_o,
  input wire trig_dio_pkg::trig_evt_t evt_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence wait_entry;
    trigger_wait_cmd_i ##1 1'b1;
  endsequence
  // A sweep step starts this count; 110 us at the 25 ns clock is 4400 cycles.
  localparam int PULSE_LAG_CYCLES = 4400;
  int unsigned lag_cycles;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lag_cycles <= 0;
    end else if (evt_o.sweep_step) begin
      lag_cycles <= 1;
    end else if (evt_o.pulse_start) begin
      lag_cycles <= 0;
    end else if (lag_cycles != 0) begin
      lag_cycles <= lag_cycles + 1;
    end
  end
  chk_reset_lines_high: assert property (
    $rose(rst_n_i) |-> (line_o & line_oe_o) == 16'hffff)
    else $error("lines not driven high after reset");
  chk_event_single: assert property (evt_o.start_meas |=> !evt_o.start_meas)
    else $error("start event longer than one cycle");
  chk_start_mode: assert property (evt_o.start_meas |-> $past(external_event_mode_i))
    else $error("start event without event mode");
  chk_status_answer: assert property (status_query_i |=> status_valid_o)
    else $error("status not answered");
  chk_status_cause: assert property (status_valid_o |-> $past(status_query_i))
    else $error("status valid without query");
  chk_wait_entry: assert property (wait_entry |-> waiting_o)
    else $error("wait state not entered");
  chk_wait_exit: assert property (
    $fell(waiting_o) |-> evt_o.wait_release || $past(evt_o.wait_release))
    else $error("wait left without trigger");
  chk_release_only: assert property (
    evt_o.wait_release |-> !(evt_o.start_meas || evt_o.sweep_step || evt_o.step_meas))
    else $error("type action during wait release");
  chk_pause_mode: assert property (
    timed_pause_cmd_i && !external_event_mode_i && !waiting_o && !trigger_wait_cmd_i
    |=> !waiting_o)
    else $error("pause entered without event mode");
  chk_pulse_lag: assert property (evt_o.pulse_start |-> lag_cycles == PULSE_LAG_CYCLES)
    else $error("pulse start not at the set lag");
endmodule
bind trig_dio_port trig_dio_port_props chk_i (
  .clk_i, .rst_n_i, .status_query_i, .trigger_wait_cmd_i,
  .timed_pause_cmd_i, .external_event_mode_i, .line_o, .line_oe_o,
  .status_valid_o, .waiting_o, .evt_o);

// ===== verif/trig_equip_model.sv
// Model of the external equipment on the trigger and line pins.
`timescale 1ns/100ps
module trig_equip_model (
  // Clock and request
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic active_high_i,
  // Line pins
  input wire logic [15:0] pin_out_i,
  input wire logic [15:0] pin_oe_i,
  input wire logic [15:0] drive_i,
  output logic [15:0] pin_o,
  output logic trig_o
);
  int unsigned hold_cnt = 0;
  // Pulses last 401 cycles, just over the minimum width, to probe the short end.
  always @(posedge clk_i) begin
    if (fire_i) begin
      hold_cnt <= 401;
    end else if (hold_cnt != 0) begin
      hold_cnt <= hold_cnt - 1;
    end
  end
  assign trig_o = active_high_i ? (hold_cnt != 0) : (hold_cnt == 0);
  assign pin_o = (pin_out_i & pin_oe_i) | (drive_i & ~pin_oe_i);
endmodule

// ===== verif/tb.sv
// Self-checking bench for the trigger and general line port.
`timescale 1ns/100ps
`define CHK(a, b) begin \
  cmp_count++; \
  if ((a) !== (b)) begin \
    miscompares++; \
    $display("MISMATCH %0t got %h want %h", $time, (a), (b)); \
  end \
end
module tb;
  int miscompares = 0;
  int cmp_count = 0;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [6:0] cmd = 7'h00;
  logic setup_input_i = 1'b1, setup_rising_i = 1'b0, external_event_mode_i = 1'b0;
  logic send_trig_i = 1'b0, fire = 1'b0, hi = 1'b0, on_line = 1'b0;
  logic [4:0] setup_port_i = 5'h00;
  logic [1:0] setup_type_i = 2'h1;
  logic [15:0] assign_out_i = 16'hffff, set_value_i = 16'h0000, set_mask_i = 16'h0000;
  logic [15:0] drive = 16'h0000, pins, line_o, line_oe_o, status_o, line_i;
  logic [23:0] delay_cycles_i = 24'h000000;
  logic ext_trig_in_i, ext_trig_out_o, status_valid_o, waiting_o, trig;
  trig_dio_pkg::trig_evt_t evt_o;
  logic [4:0] evt_q[$];
  logic [15:0] st_q[$];
  wire setup_cmd_i = cmd[0];
  wire assign_cmd_i = cmd[1];
  wire set_cmd_i = cmd[2];
  wire status_query_i = cmd[3];
  wire delay_cmd_i = cmd[4];
  wire trigger_wait_cmd_i = cmd[5];
  wire timed_pause_cmd_i = cmd[6];
  assign line_i = {pins[15:1], on_line ? trig : pins[0]};
  assign ext_trig_in_i = on_line ? 1'b1 : trig;
  trig_dio_port DUT (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .setup_cmd_i(setup_cmd_i),
    .setup_input_i(setup_input_i),
    .setup_port_i(setup_port_i),
    .setup_type_i(setup_type_i),
    .setup_rising_i(setup_rising_i),
    .assign_cmd_i(assign_cmd_i),
    .assign_out_i(assign_out_i),
    .set_cmd_i(set_cmd_i),
    .set_value_i(set_value_i),
    .set_mask_i(set_mask_i),
    .status_query_i(status_query_i),
    .delay_cmd_i(delay_cmd_i),
    .delay_cycles_i(delay_cycles_i),
    .external_event_mode_i(external_event_mode_i),
    .trigger_wait_cmd_i(trigger_wait_cmd_i),
    .timed_pause_cmd_i(timed_pause_cmd_i),
    .send_trig_i(send_trig_i),
    .ext_trig_in_i(ext_trig_in_i),
    .ext_trig_out_o(ext_trig_out_o),
    .line_i(line_i),
    .line_o(line_o),
    .line_oe_o(line_oe_o),
    .status_o(status_o),
    .status_valid_o(status_valid_o),
    .waiting_o(waiting_o),
    .evt_o(evt_o)
  );
  trig_equip_model equip (.clk_i(clk_i), .fire_i(fire), .active_high_i(hi), .pin_out_i(line_o),
    .pin_oe_i(line_oe_o), .drive_i(drive), .pin_o(pins), .trig_o(trig));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task go(input int i);
    @(posedge clk_i) cmd[i] <= 1'b1;
    @(posedge clk_i) cmd[i] <= 1'b0;
  endtask
  task fire_trig(input logic [4:0] e);
    if (e != 5'h00) evt_q.push_back(e);
    @(posedge clk_i) fire <= 1'b1;
    @(posedge clk_i) fire <= 1'b0;
    repeat (450) @(posedge clk_i);
  endtask
  task test_done;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Results are matched in order of arrival; timing is left to the checker.
  always @(posedge clk_i) begin : mon
    logic [4:0] evt_want;
    logic [15:0] st_want;
    if (rst_n_i === 1'b1 && evt_o !== 5'h00) begin
      evt_want = (evt_q.size() != 0) ? evt_q.pop_front() : 5'h1f;
      `CHK(evt_o, evt_want)
    end
    if (rst_n_i === 1'b1 && status_valid_o === 1'b1) begin
      st_want = (st_q.size() != 0) ? st_q.pop_front() : 16'hxxxx;
      `CHK(status_o, st_want)
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    test_done;
  end
  initial begin
    void'($urandom(32'h5e18));
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    `CHK(line_o & line_oe_o, 16'hffff)
    external_event_mode_i <= 1'b1;
    fire_trig(5'h10);
    external_event_mode_i <= 1'b0;
    fire_trig(5'h00);
    send_trig_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK(ext_trig_out_o, 1'b0)
    send_trig_i <= 1'b0;
    set_value_i <= 16'($urandom);
    set_mask_i <= 16'($urandom);
    assign_out_i <= 16'($urandom);
    drive <= 16'($urandom);
    go(2);
    go(1);
    repeat (3) @(posedge clk_i);
    `CHK(line_o, set_value_i | ~set_mask_i)
    `CHK(line_oe_o, assign_out_i)
    st_q.push_back(((set_value_i | ~set_mask_i) & assign_out_i) | (drive & ~assign_out_i));
    go(3);
    hi <= 1'b1;
    on_line <= 1'b1;
    repeat (8) @(posedge clk_i);
    setup_port_i <= 5'h01;
    setup_type_i <= 2'h2;
    setup_rising_i <= 1'b1;
    go(0);
    evt_q.push_back(5'h08);
    evt_q.push_back(5'h04);
    fire_trig(5'h00);
    repeat (4100) @(posedge clk_i);
    set_value_i <= 16'h0000;
    set_mask_i <= 16'hffff;
    go(2);
    repeat (3) @(posedge clk_i);
    st_q.push_back(((16'h0000 & assign_out_i) | (drive & ~assign_out_i)) & 16'hfffe);
    go(3);
    delay_cycles_i <= 24'h000014;
    setup_type_i <= 2'h3;
    go(4);
    go(0);
    fire_trig(5'h02);
    go(5);
    @(posedge clk_i);
    `CHK(waiting_o, 1'b1)
    fire_trig(5'h01);
    `CHK(waiting_o, 1'b0)
    go(6);
    repeat (2) @(posedge clk_i);
    `CHK(waiting_o, 1'b0)
    setup_input_i <= 1'b0;
    setup_port_i <= 5'h10;
    go(0);
    send_trig_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK({line_o[15], line_oe_o[15]}, 2'h3)
    send_trig_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK({line_o[15], line_oe_o[15]}, 2'h1)
    st_q.push_back((drive & ~assign_out_i) & 16'h7ffe);
    go(3);
    repeat (10) @(posedge clk_i);
    `CHK(evt_q.size() + st_q.size(), 0)
    test_done;
  end
endmodule
